//--- rtl/sild_buf.sv
module sild_buf #(
	parameter int W     = sild_pkg::WORD_W,
	parameter int DEPTH = sild_pkg::BUF_DEPTH
) (
	input  wire logic         clk_in,
	input  wire logic         reset_n_in,
	input  wire logic [W-1:0] in_data_in,
	input  wire logic         in_valid_in,
	output logic              in_ready_out,
	output logic [W-1:0]      out_data_out,
	output logic              out_valid_out,
	input  wire logic         out_ready_in
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [PW-1:0] PTR_ONE  = 1;
	localparam logic [CW-1:0] CNT_ONE  = 1;
	localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
	localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);

	logic [W-1:0]  mem_q [DEPTH];
	logic [PW-1:0] wr_q;
	logic [PW-1:0] rd_q;
	logic [CW-1:0] cnt_q;
	logic          push;
	logic          pop;

	// Honest flags from the occupancy count
	assign in_ready_out  = (cnt_q != CNT_FULL);
	assign out_valid_out = (cnt_q != '0);
	assign out_data_out  = mem_q[rd_q];
	assign push          = in_valid_in && in_ready_out;
	assign pop           = out_valid_out && out_ready_in;

	// Storage has no reset; only written slots are ever read
	always_ff @(posedge clk_in) begin
		if (push) begin
			mem_q[wr_q] <= in_data_in;
		end
	end

	// Pointers wrap at depth, which need not be a power of two
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == PTR_LAST) ? '0 : wr_q + PTR_ONE;
			end
			if (pop) begin
				rd_q <= (rd_q == PTR_LAST) ? '0 : rd_q + PTR_ONE;
			end
			if (push && !pop) begin
				cnt_q <= cnt_q + CNT_ONE;
			end else if (pop && !push) begin
				cnt_q <= cnt_q - CNT_ONE;
			end
		end
	end
endmodule

//--- rtl/sild_device.sv
module sild_device (
	input  wire logic                         clk_in,
	input  wire logic                         reset_n_in,
	output logic [sild_pkg::WORD_W-1:0]       sink_on_out,
	output logic [sild_pkg::WORD_W-1:0]       storage_out,
	sild_if.device                            link
);
	logic [sild_pkg::SY_W-1:0]   sy_a_q;
	logic [sild_pkg::SY_W-1:0]   sy_b_q;
	logic [sild_pkg::SY_W-1:0]   sy_c_q;
	logic [sild_pkg::SY_W-1:0]   lvl_q;
	logic [sild_pkg::SY_W-1:0]   agree;
	logic [sild_pkg::WORD_W-1:0] shift_q;
	logic [sild_pkg::WORD_W-1:0] store_q;
	logic [sild_pkg::WORD_W-1:0] sink_q;
	logic                        casc_q;
	logic                        clear_act;
	logic                        shift_rise;
	logic                        shift_fall;
	logic                        latch_rise;

	// Rising edge once stages two and three agree on a new high
	function automatic logic rise_of(input logic b, input logic c, input logic l);
		rise_of = b && c && !l;
	endfunction

	// Three-stage synchroniser; pins are asynchronous to clk_in
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			sy_a_q <= sild_pkg::SY_RST;
			sy_b_q <= sild_pkg::SY_RST;
			sy_c_q <= sild_pkg::SY_RST;
		end else begin
			sy_a_q <= {link.serial_input_pin, link.output_enable_n,
				link.register_clear_n, link.latch_clock, link.shift_clock};
			sy_b_q <= sy_a_q;
			sy_c_q <= sy_b_q;
		end
	end

	assign agree = ~(sy_b_q ^ sy_c_q);

	// Filtered level changes only where stages agree
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			lvl_q <= sild_pkg::SY_RST;
		end else begin
			lvl_q <= (agree & sy_c_q) | (~agree & lvl_q);
		end
	end

	assign clear_act  = !lvl_q[sild_pkg::SY_CLR_N];
	assign shift_rise = rise_of(sy_b_q[sild_pkg::SY_SHIFT], sy_c_q[sild_pkg::SY_SHIFT],
		lvl_q[sild_pkg::SY_SHIFT]);
	assign shift_fall = rise_of(!sy_b_q[sild_pkg::SY_SHIFT], !sy_c_q[sild_pkg::SY_SHIFT],
		!lvl_q[sild_pkg::SY_SHIFT]);
	assign latch_rise = rise_of(sy_b_q[sild_pkg::SY_LATCH], sy_c_q[sild_pkg::SY_LATCH],
		lvl_q[sild_pkg::SY_LATCH]);

	// Shift stages; clear holds them at zero and masks the clock
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			shift_q <= sild_pkg::WORD_ZERO;
		end else if (clear_act) begin
			shift_q <= sild_pkg::WORD_ZERO;
		end else if (shift_rise) begin
			shift_q <= {shift_q[sild_pkg::MSB-1:0], sy_c_q[sild_pkg::SY_DATA]};
		end
	end

	// Storage stages copy all eight bits on a latch edge
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			store_q <= sild_pkg::WORD_ZERO;
		end else if (clear_act) begin
			store_q <= sild_pkg::WORD_ZERO;
		end else if (latch_rise) begin
			store_q <= shift_q;
		end
	end

	// Cascade moves on the falling edge for downstream hold margin
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			casc_q <= 1'b0;
		end else if (clear_act) begin
			casc_q <= 1'b0;
		end else if (shift_fall) begin
			casc_q <= shift_q[sild_pkg::MSB];
		end
	end

	// Output buffers: gated by clear and enable, one means sinking
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			sink_q <= sild_pkg::WORD_ZERO;
		end else if (clear_act || lvl_q[sild_pkg::SY_OE_N]) begin
			sink_q <= sild_pkg::WORD_ZERO;
		end else begin
			sink_q <= store_q;
		end
	end

	assign sink_on_out         = sink_q;
	assign storage_out         = store_q;
	assign link.cascade_output = casc_q;
endmodule

//--- rtl/sild_host.sv
module sild_host (
	input  wire logic                         clk_in,
	input  wire logic                         reset_n_in,
	input  wire logic [sild_pkg::WORD_W-1:0]  word_in,
	input  wire logic                         word_valid_in,
	output logic                              word_ready_out,
	input  wire logic                         dim_n_in,
	output logic                              busy_out,
	sild_if.host                              link
);
	localparam logic [sild_pkg::DIV_W-1:0] DIV_END =
		sild_pkg::DIV_W'(sild_pkg::SHIFT_HALF_CYC - 1);
	localparam logic [sild_pkg::DIV_W-1:0] DIV_ONE = 1;
	localparam logic [sild_pkg::CLR_W-1:0] CLR_END =
		sild_pkg::CLR_W'(sild_pkg::CLEAR_CYC - 1);
	localparam logic [sild_pkg::CLR_W-1:0] CLR_ONE = 1;
	localparam logic [sild_pkg::BIT_W-1:0] BIT_ONE = 1;

	sild_pkg::sild_state_e         state_q;
	logic [sild_pkg::DIV_W-1:0]    div_q;
	logic [sild_pkg::CLR_W-1:0]    clr_cnt_q;
	logic [sild_pkg::BIT_W-1:0]    bit_q;
	logic [sild_pkg::WORD_W-1:0]   word_q;
	logic [sild_pkg::WORD_W-1:0]   buf_data;
	logic                          buf_valid;
	logic                          buf_take;
	logic                          tick;
	logic                          sclk_q;
	logic                          latch_q;
	logic                          clr_n_q;
	logic                          oe_n_q;
	logic                          sdata_q;

	// Two-entry buffer absorbs a word while the previous one shifts
	sild_buf u_buf (
		.clk_in        (clk_in),
		.reset_n_in    (reset_n_in),
		.in_data_in    (word_in),
		.in_valid_in   (word_valid_in),
		.in_ready_out  (word_ready_out),
		.out_data_out  (buf_data),
		.out_valid_out (buf_valid),
		.out_ready_in  (buf_take)
	);

	assign buf_take = (state_q == sild_pkg::ST_IDLE) && buf_valid && tick;
	assign busy_out = (state_q != sild_pkg::ST_IDLE);
	assign tick     = (div_q == DIV_END);

	// Half-period enable keeps the shift clock at 160 ns
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			div_q <= '0;
		end else begin
			div_q <= tick ? '0 : div_q + DIV_ONE;
		end
	end

	// Sequencer: clear, then per word eight shift clocks and one latch
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state_q   <= sild_pkg::ST_CLEAR;
			clr_cnt_q <= '0;
			bit_q     <= '0;
			word_q    <= sild_pkg::WORD_ZERO;
			sclk_q    <= 1'b0;
			latch_q   <= 1'b0;
			clr_n_q   <= 1'b0;
			sdata_q   <= 1'b0;
		end else begin
			case (state_q)
				sild_pkg::ST_CLEAR: begin
					clr_n_q <= 1'b0;
					if (clr_cnt_q == CLR_END) begin
						clr_n_q <= 1'b1;
						state_q <= sild_pkg::ST_IDLE;
					end else begin
						clr_cnt_q <= clr_cnt_q + CLR_ONE;
					end
				end
				sild_pkg::ST_IDLE: begin
					if (buf_take) begin
						// Most significant bit first, so it lands on output seven
						word_q  <= buf_data;
						sdata_q <= buf_data[sild_pkg::MSB];
						bit_q   <= '0;
						state_q <= sild_pkg::ST_LOW;
					end
				end
				sild_pkg::ST_LOW: begin
					if (tick) begin
						sclk_q  <= 1'b1;
						state_q <= sild_pkg::ST_HIGH;
					end
				end
				sild_pkg::ST_HIGH: begin
					if (tick) begin
						sclk_q <= 1'b0;
						if (bit_q == sild_pkg::LAST_BIT) begin
							latch_q <= 1'b1;
							state_q <= sild_pkg::ST_LATCH;
						end else begin
							word_q  <= {word_q[sild_pkg::MSB-1:0], 1'b0};
							sdata_q <= word_q[sild_pkg::MSB-1];
							bit_q   <= bit_q + BIT_ONE;
							state_q <= sild_pkg::ST_LOW;
						end
					end
				end
				sild_pkg::ST_LATCH: begin
					if (tick) begin
						latch_q <= 1'b0;
						state_q <= sild_pkg::ST_DONE;
					end
				end
				sild_pkg::ST_DONE: begin
					if (tick) begin
						state_q <= sild_pkg::ST_IDLE;
					end
				end
				default: begin
					state_q <= sild_pkg::ST_CLEAR;
				end
			endcase
		end
	end

	// Enable follows the user dimming input, no reload needed
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			oe_n_q <= 1'b1;
		end else begin
			oe_n_q <= dim_n_in;
		end
	end

	assign link.shift_clock      = sclk_q;
	assign link.latch_clock      = latch_q;
	assign link.register_clear_n = clr_n_q;
	assign link.output_enable_n  = oe_n_q;
	assign link.serial_input_pin = sdata_q;
endmodule

//--- rtl/sild_if.sv
interface sild_if;
	logic shift_clock;
	logic latch_clock;
	logic register_clear_n;
	logic output_enable_n;
	logic serial_input_pin;
	logic cascade_output;

	modport host (
		output shift_clock,
		output latch_clock,
		output register_clear_n,
		output output_enable_n,
		output serial_input_pin
	);
	modport device (
		input  shift_clock,
		input  latch_clock,
		input  register_clear_n,
		input  output_enable_n,
		input  serial_input_pin,
		output cascade_output
	);
endinterface

//--- rtl/sild_pkg.sv
// What this block does
// - Eight-bit shift register, rising shift clock
// - Rising latch clock copies shift into storage
// - Storage reaches outputs only while clear high
// - Clear low zeroes shift and storage stages
// - Host holds clear low at initialization
// - Enable high forces all sink outputs off
// - Enable low makes outputs follow storage
// - Bit one sinks current, zero is off
// - Host may pulse enable for dimming
// - Cascade output updates on falling shift clock
// - Cascade feeds next serial input, shared clock
// - Host shift clock at most ten megahertz
// - Shift whole chain, then one latch pulse
package sild_pkg;
	localparam int WORD_W        = 8;
	localparam int BUF_DEPTH     = 2;
	localparam int CLK_NS        = 20;
	// Half period of the host shift clock; 80 ns gives 160 ns, under 10 MHz
	localparam int SHIFT_HALF_NS = 80;
	localparam int SHIFT_HALF_CYC = (SHIFT_HALF_NS + CLK_NS - 1) / CLK_NS;
	localparam int CLEAR_NS      = 160;
	localparam int CLEAR_CYC     = (CLEAR_NS + CLK_NS - 1) / CLK_NS;
	localparam int DIV_W         = 3;
	localparam int CLR_W         = 4;
	localparam int BIT_W         = 3;
	localparam logic [BIT_W-1:0] LAST_BIT = 3'h7;
	localparam int MSB           = WORD_W - 1;
	// Synchroniser bit positions of device pins
	localparam int SY_SHIFT = 0;
	localparam int SY_LATCH = 1;
	localparam int SY_CLR_N = 2;
	localparam int SY_OE_N  = 3;
	localparam int SY_DATA  = 4;
	localparam int SY_W     = 5;
	// Clear asserted and outputs disabled while in reset
	localparam logic [SY_W-1:0] SY_RST = 5'h08;
	localparam logic [WORD_W-1:0] WORD_ZERO = 8'h00;

	typedef enum logic [5:0] {
		ST_CLEAR = 6'h01,
		ST_IDLE  = 6'h02,
		ST_LOW   = 6'h04,
		ST_HIGH  = 6'h08,
		ST_LATCH = 6'h10,
		ST_DONE  = 6'h20
	} sild_state_e;
endpackage

//--- tb/sild_chk.sv
module sild_chk (
	input  wire logic clk_in,
	input  wire logic reset_n_in,
	input  wire logic shift_clock,
	input  wire logic latch_clock,
	input  wire logic register_clear_n,
	input  wire logic output_enable_n,
	input  wire logic serial_input_pin,
	input  wire logic cascade_output
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       sc_q;
	logic       lc_q;
	logic [3:0] rise_cnt_q;
	logic [3:0] up_cnt_q;

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!reset_n_in);

	// Shift rises since last latch rise, and cycles since reset release
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			sc_q <= 1'b0;
			lc_q <= 1'b0;
			rise_cnt_q <= 4'h0;
			up_cnt_q <= 4'h0;
		end else begin
			sc_q <= shift_clock;
			lc_q <= latch_clock;
			if (latch_clock && !lc_q) begin
				rise_cnt_q <= 4'h0;
			end else if (shift_clock && !sc_q) begin
				rise_cnt_q <= rise_cnt_q + 4'h1;
			end
			if (up_cnt_q != 4'hF) begin
				up_cnt_q <= up_cnt_q + 4'h1;
			end
		end
	end

	// Half periods of four cycles keep the link clock under its limit
	a_shift_high_width: assert property ($rose(shift_clock) |=> shift_clock[*3])
		else $error("shift clock high phase too short");
	a_shift_low_width: assert property ($fell(shift_clock) |=> (!shift_clock)[*3])
		else $error("shift clock low phase too short");
	a_latch_after_word: assert property ($rose(latch_clock) |-> rise_cnt_q == 4'h8 && !shift_clock)
		else $error("latch pulse not after eight shift rises");
	a_data_hold: assert property (shift_clock && $past(shift_clock) |-> $stable(serial_input_pin))
		else $error("serial data moved while shift clock high");
	// Pins reach the device four cycles late; a move outside clear follows a fall
	a_cascade_on_fall: assert property ($changed(cascade_output) && register_clear_n
		|-> $past(shift_clock, 5) && !$past(shift_clock, 4))
		else $error("cascade output moved without a shift clock fall");
	a_cascade_cleared: assert property ((!register_clear_n)[*6] |-> !cascade_output)
		else $error("cascade output not cleared");
	a_clear_at_start: assert property (up_cnt_q < 4'h7 |-> !register_clear_n)
		else $error("clear not held after reset");
	a_clear_holds_clocks: assert property (!register_clear_n |-> !shift_clock && !latch_clock)
		else $error("clock active during clear");
endmodule

//--- tb/sild_tb.sv
module sild_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic                        clk_in;
	logic                        host_rst_n;
	logic                        dev_rst_n;
	logic [sild_pkg::WORD_W-1:0] word_in;
	logic                        word_valid_in;
	logic                        word_ready_out;
	logic                        dim_n_in;
	logic                        busy_out;
	logic [sild_pkg::WORD_W-1:0] sink_on_out;
	logic [sild_pkg::WORD_W-1:0] storage_out;
	logic [7:0]                  words [6] = '{8'hA5, 8'h01, 8'h80, 8'hFF, 8'h00, 8'h5A};
	int                          err_total;
	int                          checks;

	sild_if link_i ();
	sild_host sild_host_i (.clk_in(clk_in), .reset_n_in(host_rst_n), .word_in(word_in),
		.word_valid_in(word_valid_in), .word_ready_out(word_ready_out), .dim_n_in(dim_n_in),
		.busy_out(busy_out), .link(link_i));
	sild_device sild_device_i (.clk_in(clk_in), .reset_n_in(dev_rst_n), .sink_on_out(sink_on_out),
		.storage_out(storage_out), .link(link_i));
	sild_chk sild_chk_i (.clk_in(clk_in), .reset_n_in(host_rst_n),
		.shift_clock(link_i.shift_clock), .latch_clock(link_i.latch_clock),
		.register_clear_n(link_i.register_clear_n), .output_enable_n(link_i.output_enable_n),
		.serial_input_pin(link_i.serial_input_pin), .cascade_output(link_i.cascade_output));

	// Free-running system clock
	initial clk_in = 1'b0;
	always #10 clk_in = ~clk_in;

	task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Offer one word and hold it until the edge that takes it
	task push(input logic [7:0] w);
		int n;
		n = 0;
		@(posedge clk_in);
		#2;
		word_in = w;
		word_valid_in = 1'b1;
		// Ready is looked at off the edge, where it has settled
		while (word_ready_out !== 1'b1 && n < 400) begin
			@(posedge clk_in);
			#2;
			n++;
		end
		@(posedge clk_in);
		#2;
		if (n >= 400) err_total++;
		word_valid_in = 1'b0;
	endtask

	// Idle must last past one divider tick, else a queued word may still wait
	task settle;
		int quiet;
		int n;
		quiet = 0;
		n = 0;
		while (quiet < 8 && n < 2000) begin
			@(posedge clk_in);
			#2;
			n++;
			quiet = (busy_out === 1'b0) ? quiet + 1 : 0;
		end
		if (quiet < 8) err_total++;
	endtask

	task wait_cyc(input int c);
		repeat (c) @(posedge clk_in);
		#2;
	endtask

	task stop_test;
		$display("Checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		word_in = 8'h00;
		word_valid_in = 1'b0;
		dim_n_in = 1'b0;
		host_rst_n = 1'b0;
		dev_rst_n = 1'b0;
		err_total = 0;
		checks = 0;
		wait_cyc(8);
		host_rst_n = 1'b1;
		dev_rst_n = 1'b1;
		settle();
		check("storage", storage_out, 8'h00);
		check("sink", sink_on_out, 8'h00);
		$display("Test init done");
		foreach (words[i]) begin
			push(words[i]);
			settle();
			check("storage", storage_out, words[i]);
			check("sink", sink_on_out, words[i]);
			check("cascade", {7'h00, link_i.cascade_output}, {7'h00, words[i][7]});
		end
		$display("Test words done");
		push(8'h11);
		push(8'h22);
		push(8'h33);
		wait_cyc(6);
		check("ready", {7'h00, word_ready_out}, 8'h00);
		push(8'hC3);
		settle();
		check("storage", storage_out, 8'hC3);
		$display("Test back to back done");
		dim_n_in = 1'b1;
		wait_cyc(10);
		check("sink", sink_on_out, 8'h00);
		check("storage", storage_out, 8'hC3);
		dim_n_in = 1'b0;
		wait_cyc(10);
		check("sink", sink_on_out, 8'hC3);
		$display("Test dimming done");
		push(8'h7E);
		wait_cyc(20);
		host_rst_n = 1'b0;
		wait_cyc(2);
		host_rst_n = 1'b1;
		settle();
		check("storage", storage_out, 8'h00);
		check("sink", sink_on_out, 8'h00);
		check("cascade", {7'h00, link_i.cascade_output}, 8'h00);
		push(8'h96);
		settle();
		check("storage", storage_out, 8'h96);
		$display("Test clear done");
		stop_test();
	end

	// Tests need about 1000 cycles; twenty times that means a hang
	initial begin
		#400000;
		err_total++;
		stop_test();
	end
endmodule
